// File: design/dac_latch_pkg.sv
// constants and types for the parallel-input converter latch
package dac_latch_pkg;
  localparam int DATA_W = 10;
  localparam int FIFO_DEPTH = 8;
  localparam logic [9:0] CODE_MAX = 10'h3FF;
  localparam logic [10:0] FULL_SCALE = 11'h400;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_DOWN_NS = 50;
  localparam int WAKE_UP_NS = 5000;
  // longest time rounds down, never below one cycle
  localparam int SLEEP_DOWN_CYC = (SLEEP_DOWN_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (SLEEP_DOWN_NS / CLK_PERIOD_NS);
  // least time rounds up
  localparam int WAKE_UP_CYC = (WAKE_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_UP_CYC8 = 8'(WAKE_UP_CYC);
  localparam logic [9:0] CODE_RST = 10'h000;
  typedef enum logic [2:0] {
    PWR_ON = 3'h1,
    PWR_SLEEP = 3'h2,
    PWR_WAKE = 3'h4
  } pwr_state_t;
endpackage

// File: design/sample_stream_if.sv
// valid/ready word carrier between the latch and its fifo
`timescale 1ns/1ns
`default_nettype none
interface sample_stream_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: design/sample_fifo.sv
// parameterised sample fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  sample_stream_if.snk wr,
  // drain side
  sample_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem[rp_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_no_overflow;
    @(posedge clk) disable iff (!rst_n)
    (cnt_q == (AW+1)'(DEPTH)) |-> !wr.ready && (wp_q == rp_q);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("fifo written while full");
endmodule
`default_nettype wire

// File: design/dac_parallel_input_latch.sv
// converter front end: word latch, sample fifo, sleep control and output split
// Notes on behaviour
// - one clock input plus a ten-line parallel sample word
// - word is unsigned binary, highest line msb, line zero lsb
// - all ones puts full scale on primary; complementary carries remainder
// - word captured and output updated on rising clock edges only
// - runs to the top sample rate; clock source keeps pulse width
// - sleep high powers down: output current off, supply lowered
// - sleep input pulled low so an open pin leaves device running
// - power-down within 50 ns (here outputs go off two to three clocks after sleep rises), resume about 5 us after release
// - primary is code/1024, complementary (1023-code)/1024 of full scale
`timescale 1ns/1ns
`default_nettype none
module dac_parallel_input_latch
  import dac_latch_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // sample source
  input wire logic [DATA_W-1:0] sample_word,
  input wire logic sample_valid,
  output logic sample_ready,
  // power control, pin is pulled low outside
  input wire logic sleep,
  // converted outputs, in 1/1024 of full scale, then enable and supply flags
  output logic [DATA_W-1:0] primary_current_output,
  output logic [DATA_W-1:0] complementary_current_output,
  output logic output_enabled,
  output logic supply_reduced
);
  logic rst_s1_q;
  logic rst_n;
  logic sleep_s1_q;
  logic sleep_s2_q;
  logic [DATA_W-1:0] word_s1_q;
  logic [DATA_W-1:0] word_s2_q;
  logic valid_s1_q;
  logic valid_s2_q;
  logic [DATA_W-1:0] code_q;
  pwr_state_t pwr_q;
  pwr_state_t pwr_d;
  logic [7:0] wake_cnt_q;
  logic converting;

  sample_stream_if #(.W(DATA_W)) fill ();
  sample_stream_if #(.W(DATA_W)) drain ();

  // reset release through two flops
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // pin inputs pass two flops; the first stage feeds nothing else
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
      word_s1_q <= CODE_RST;
      word_s2_q <= CODE_RST;
      valid_s1_q <= 1'b0;
      valid_s2_q <= 1'b0;
    end
    else
    begin
      sleep_s1_q <= sleep;
      sleep_s2_q <= sleep_s1_q;
      word_s1_q <= sample_word;
      word_s2_q <= word_s1_q;
      valid_s1_q <= sample_valid;
      valid_s2_q <= valid_s1_q;
    end
  end

  // ready is a level; a full fifo back-pressures the source
  assign sample_ready = fill.ready;
  assign fill.valid = valid_s2_q;
  assign fill.data = word_s2_q;

  sample_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .wr(fill),
    .rd(drain)
  );

  // drain only while converting, so the fifo really fills in sleep
  assign converting = (pwr_q == PWR_ON);
  assign drain.ready = converting;

  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ON:
      begin
        if (sleep_s2_q)
        begin
          pwr_d = PWR_SLEEP;
        end
      end
      PWR_SLEEP:
      begin
        if (!sleep_s2_q)
        begin
          pwr_d = PWR_WAKE;
        end
      end
      PWR_WAKE:
      begin
        if (sleep_s2_q)
        begin
          pwr_d = PWR_SLEEP;
        end
        else if (wake_cnt_q == 8'h00)
        begin
          pwr_d = PWR_ON;
        end
      end
      default:
      begin
        pwr_d = PWR_ON;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_q <= PWR_ON;
    end
    else
    begin
      pwr_q <= pwr_d;
    end
  end

  // wake timer loads on the way into the wake state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_cnt_q <= 8'h00;
    end
    else if (pwr_q != PWR_WAKE)
    begin
      wake_cnt_q <= WAKE_UP_CYC8 - 8'h01;
    end
    else if (wake_cnt_q != 8'h00)
    begin
      wake_cnt_q <= wake_cnt_q - 8'h01;
    end
  end

  // master/slave capture on rising edges only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_q <= CODE_RST;
    end
    else if (drain.valid && drain.ready)
    begin
      code_q <= drain.data;
    end
  end

  // outputs from flops; sleep forces both currents off
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_current_output <= '0;
      complementary_current_output <= '0;
      output_enabled <= 1'b0;
      supply_reduced <= 1'b0;
    end
    else
    begin
      // enable follows the same next state as the currents, so the pair never splits
      output_enabled <= (pwr_d == PWR_ON);
      supply_reduced <= (pwr_d != PWR_ON);
      if (pwr_d != PWR_ON)
      begin
        primary_current_output <= '0;
        complementary_current_output <= '0;
      end
      else
      begin
        primary_current_output <= code_q;
        complementary_current_output <= CODE_MAX - code_q;
      end
    end
  end

  property p_sum_full;
    @(posedge core_clk) disable iff (!rst_n)
    output_enabled && $past(output_enabled) |->
      (11'(primary_current_output) + 11'(complementary_current_output)
       == FULL_SCALE - 11'h001);
  endproperty
  a_sum_full: assert property (p_sum_full)
    else $error("outputs do not share full scale");

  property p_sleep_off;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(sleep_s2_q) |=> ##[0:1] (primary_current_output == '0 && supply_reduced);
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("power-down too slow");

  property p_wake_wait;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(sleep_s2_q) |=> !converting [*8];
  endproperty
  a_wake_wait: assert property (p_wake_wait)
    else $error("resumed before wake interval");

  property p_wake_done;
    @(posedge core_clk) disable iff (!rst_n)
    (pwr_q == PWR_WAKE && wake_cnt_q == 8'h00 && !sleep_s2_q) |=> converting;
  endproperty
  a_wake_done: assert property (p_wake_done)
    else $error("wake did not complete");

  property p_sleep_holds;
    @(posedge core_clk) disable iff (!rst_n)
    sleep_s2_q |=> !converting;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("converting while asleep");

  property p_capture;
    @(posedge core_clk) disable iff (!rst_n)
    (drain.valid && drain.ready) |=> (code_q == $past(drain.data));
  endproperty
  a_capture: assert property (p_capture)
    else $error("sample not latched");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !(drain.valid && drain.ready) |=> $stable(code_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("code changed without a sample");

  property p_primary;
    @(posedge core_clk) disable iff (!rst_n)
    converting && (pwr_d == PWR_ON) |=> primary_current_output == $past(code_q);
  endproperty
  a_primary: assert property (p_primary)
    else $error("primary output wrong");

  property p_ready_full;
    @(posedge core_clk) disable iff (!rst_n)
    !converting [*8] |-> ##[0:20] !sample_ready || !valid_s2_q;
  endproperty
  a_ready_full: assert property (p_ready_full)
    else $error("fifo did not back-pressure");
endmodule
`default_nettype wire

// File: dv/sample_source.sv
// sample source model driving the parallel word and its valid
`timescale 1ns/1ns
`default_nettype none
module sample_source
  import dac_latch_pkg::*;
(
  // clock and back-pressure
  input wire logic clk,
  input wire logic ready,
  // sample lines
  output logic [DATA_W-1:0] word,
  output logic valid
);
  initial
  begin
    word = '0;
    valid = 1'b0;
  end
  // changes land on the falling edge, far from the capturing edge
  task automatic push(input logic [DATA_W-1:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    ok = (ready === 1'b1);
    word <= w;
    valid <= ok;
  endtask
  // a released bus shows the inverse of its last value, not a held copy
  task automatic idle();
    @(negedge clk);
    valid <= 1'b0;
    word <= ~word;
  endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the converter front end
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dac_latch_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sleep = 1'b0;
  logic [DATA_W-1:0] word, prim, comp, last_w, prev_p, held_w;
  logic valid, ready, out_en, sup_red;
  logic was_en = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] edges[7] = '{10'h3FF, 10'h000, 10'h200, 10'h1FF, 10'h155, 10'h2AA, 10'h001};
  int fails = 0;
  int check_count = 0;
  integer seed = 32'hF837C02B;
  int cnt;
  bit ok;
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  sample_source src (.clk(core_clk), .ready(ready), .word(word), .valid(valid));
  dac_parallel_input_latch DUT (.core_clk(core_clk), .nrst(nrst), .sample_word(word),
    .sample_valid(valid), .sample_ready(ready), .sleep(sleep), .primary_current_output(prim),
    .complementary_current_output(comp), .output_enabled(out_en), .supply_reduced(sup_red));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bad(input string m);
    fails++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic chk_code(input logic [DATA_W-1:0] p, c, e);
    check_count++;
    if (p !== e || c !== CODE_MAX - e)
      bad($sformatf("outputs %h/%h for code %h", p, c, e));
  endtask
  task automatic chk_bit(input logic g, e, input string m);
    check_count++;
    if (g !== e)
      bad(m);
  endtask
  task automatic send(input logic [DATA_W-1:0] w);
    exp_q.push_back(w);
    last_w = w;
    src.push(w, ok);
    if (!ok)
    begin
      bad("source stalled");
      finish_test();
    end
  endtask
  // neighbours differ, so every new sample shows as a change at the outputs
  task automatic send_rand(input int n);
    logic [DATA_W-1:0] w;
    repeat (n)
    begin
      w = last_w;
      while (w == last_w || w == '0)
        w = DATA_W'($random(seed));
      send(w);
    end
    src.idle();
  endtask
  task automatic drain();
    cnt = 0;
    while (exp_q.size() != 0 && cnt < 400)
    begin
      @(negedge core_clk);
      cnt++;
    end
    if (exp_q.size() != 0)
    begin
      bad("samples never reached outputs");
      finish_test();
    end
  endtask
  // counts cycles from the release of sleep until converting again
  task automatic wake_wait();
    cnt = 0;
    while (out_en !== 1'b1 && cnt < 300)
    begin
      @(negedge core_clk);
      cnt++;
      if (cnt == 60)
        chk_bit(sup_red, 1'b1, "woke early");
    end
    chk_bit(cnt >= WAKE_UP_CYC && cnt <= WAKE_UP_CYC + 6, 1'b1, "wake time");
    if (out_en !== 1'b1)
      finish_test();
  endtask
  // output watcher: a changed code while converting is the next sample
  always @(negedge core_clk)
  begin
    if (out_en === 1'b1)
    begin
      if (was_en === 1'b1 && prim !== prev_p)
      begin
        if (exp_q.size() == 0)
          bad("unexpected sample");
        else
          chk_code(prim, comp, exp_q.pop_front());
      end
      prev_p = prim;
      was_en = 1'b1;
    end
    else
      was_en = 1'b0;
  end
  initial
  begin
    last_w = '0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    cnt = 0;
    while (out_en !== 1'b1 && cnt < 10)
    begin
      @(negedge core_clk);
      cnt++;
    end
    chk_bit(out_en, 1'b1, "not converting after reset");
    if (out_en !== 1'b1)
      finish_test();
    foreach (edges[i])
      send(edges[i]);
    send_rand(20);
    drain();
    held_w = last_w;
    @(posedge core_clk);
    sleep <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk_bit(prim === '0 && comp === '0, 1'b1, "current not off");
    chk_bit(sup_red, 1'b1, "supply not reduced");
    chk_bit(out_en, 1'b0, "still converting asleep");
    send_rand(FIFO_DEPTH);
    repeat (4) @(negedge core_clk);
    chk_bit(ready, 1'b0, "full buffer not refusing");
    chk_bit(prim === '0 && DUT.code_q === held_w, 1'b1, "drained while asleep");
    @(posedge core_clk);
    sleep <= 1'b0;
    wake_wait();
    drain();
    send_rand(40);
    drain();
    // sleep again part way through waking: the wake interval starts over
    @(posedge core_clk);
    sleep <= 1'b1;
    repeat (6) @(posedge core_clk);
    sleep <= 1'b0;
    repeat (40) @(posedge core_clk);
    sleep <= 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk_bit(out_en, 1'b0, "converting after sleep in wake");
    @(posedge core_clk);
    sleep <= 1'b0;
    wake_wait();
    finish_test();
  end
endmodule
`default_nettype wire
